/* File: cip_pkg.sv */
// Constants and types of the control character interpreter.
// Assumes: compiled before every other cip_ design file.
`default_nettype none
package cip_pkg;
    ////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the AXI4-Lite bus
    localparam int unsigned AW        = 8;
    localparam logic [7:0]  REG_CTRL  = 8'h00;
    localparam logic [7:0]  REG_STAT  = 8'h04;
    localparam logic [7:0]  REG_MASK  = 8'h08;
    localparam logic [7:0]  REG_STATE = 8'h0c;
    localparam logic [7:0]  REG_DLE   = 8'h10;
    localparam logic [7:0]  REG_TBL   = 8'h40;
    localparam logic [7:0]  DLE_RESET = 8'h10;
    localparam int unsigned CTRL_LRC  = 0;
    localparam int unsigned CTRL_CMD  = 1;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;
    ////////////////////////////////////////////////////////////////////
    // Word layout: byte 0 high half, bit 0 is the MSB of each byte
    localparam int unsigned B0_ITB    = 15;
    localparam int unsigned B0_END    = 14;
    localparam int unsigned B0_ABORT  = 13;
    localparam int unsigned B0_STBCC  = 12;
    localparam int unsigned B0_SUPCH  = 11;
    localparam int unsigned B0_MON    = 9;
    localparam int unsigned B0_STCH   = 8;
    localparam int unsigned B1_EXCL   = 3;
    localparam int unsigned B1_RSTTR  = 2;
    localparam int unsigned B1_SETTR  = 1;
    localparam int unsigned B1_SKIP   = 0;
    localparam logic [15:0] WORD_MASK = 16'hff0f;
    ////////////////////////////////////////////////////////////////////
    // Sticky event bits
    localparam int unsigned NEV       = 6;
    localparam int unsigned EV_END    = 0;
    localparam int unsigned EV_ITB    = 1;
    localparam int unsigned EV_ABORT  = 2;
    localparam int unsigned EV_MON    = 3;
    localparam int unsigned EV_BCCERR = 4;
    localparam int unsigned EV_TRANS  = 5;

    typedef enum logic [2:0]
    {
        FLOW_RUN   = 3'b001,
        FLOW_CHECK = 3'b010,
        FLOW_HALT  = 3'b100
    } cip_flow_e;

    typedef struct packed {
        logic [7:0] data;
        logic       ctrl;
        logic [3:0] word;
        logic       dir_out;
    } cip_char_s;

    typedef struct packed {
        logic itb, fin, abort, stbcc, supch, mon, stch;
        logic excl, rsttr, settr, skip;
    } cip_fn_s;

    // End plus monitor acts as intermediate block only
    function automatic cip_fn_s cip_decode(input logic [15:0] w);
        cip_fn_s f;
        f.itb   = w[B0_ITB] | (w[B0_END] & w[B0_MON]);
        f.fin   = w[B0_END] & ~w[B0_MON];
        f.mon   = w[B0_MON] & ~w[B0_END];
        f.abort = w[B0_ABORT];
        f.stbcc = w[B0_STBCC];
        f.supch = w[B0_SUPCH];
        f.stch  = w[B0_STCH];
        f.excl  = w[B1_EXCL];
        f.rsttr = w[B1_RSTTR];
        f.settr = w[B1_SETTR];
        f.skip  = w[B1_SKIP];
        return f;
    endfunction : cip_decode
endpackage : cip_pkg
`default_nettype wire

/* File: cip_interp_table.sv */
// Sixteen-word interpretation table, one write and two read ports.
// Assumes: writes come from the register block, reads are combinational.
`timescale 1ns/10ps
`default_nettype none
module cip_interp_table
    import cip_pkg::*;
#(
    parameter int unsigned DEPTH = 16
)
(
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // Write port
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [15:0]              wdata,
    // Read ports
    input  wire logic [$clog2(DEPTH)-1:0] raddr_a,
    output logic      [15:0]              rdata_a,
    input  wire logic [$clog2(DEPTH)-1:0] raddr_b,
    output logic      [15:0]              rdata_b
);
    typedef struct packed {
        logic [DEPTH-1:0][15:0] w;
    } cip_tbl_s;

    cip_tbl_s q, d;

    always_comb
    begin
        d = q;
        if (we)
        begin
            d.w[waddr] = wdata & WORD_MASK;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '0;
        else
            q <= d;
    end

    assign rdata_a = q.w[raddr_a];
    assign rdata_b = q.w[raddr_b];
endmodule : cip_interp_table
`default_nettype wire

/* File: cip_block_check.sv */
// Longitudinal block check accumulator (byte-wise XOR).
// Assumes: clear drops the old sum and both add inputs of the cycle.
`timescale 1ns/10ps
`default_nettype none
module cip_block_check
    import cip_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control
    input  wire logic       clr,
    input  wire logic       a_en,
    input  wire logic [7:0] a,
    input  wire logic       b_en,
    input  wire logic [7:0] b,
    // Sum
    output logic      [7:0] acc
);
    typedef struct packed {
        logic [7:0] acc;
    } cip_bcc_s;

    cip_bcc_s q, d;

    always_comb
    begin
        d.acc = q.acc ^ (a_en ? a : 8'h00) ^ (b_en ? b : 8'h00);
        if (clr)
            d.acc = 8'h00;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '0;
        else
            q <= d;
    end

    assign acc = q.acc;
endmodule : cip_block_check
`default_nettype wire

/* File: cip_char_interp.sv */
// Control character interpreter of a line adapter port, AXI4-Lite regs.
// Assumes: one character per valid cycle, detect lookup done upstream.
//
// Functional notes
// - Byte1 bit4 after start: detected char and preceding DLE skip check
// - That DLE-pair exclusion works only when LRC parity is configured
// - Byte1 bit5 leaves transparent mode, input only, after a DLE
// - Leaving transparent needs end or intermediate-block bit too
// - Byte1 bit6 enters transparent mode both directions, after a DLE
// - Byte1 bit7 keeps the char out of check, ignored when transparent
// - Check-skipped char still goes to host unless suppress-char set
// - End plus monitor acts as intermediate block only
// - Word 0801 means suppress character plus skip block check
// - Word 1101 means start check, start char, skip check together
// - Word 4800 means end plus suppress char, terminator not passed
// - End sets status and halts flow; on input it checks the following block check, on output it sends the check
// - Intermediate block on output sends check and restarts it
// - Suppress-char bit keeps input char from host, input only
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cip_char_interp
    import cip_pkg::*;
(
    // Clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // AXI4-Lite write
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic      [1:0]    s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // AXI4-Lite read
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic      [31:0]   s_axi_rdata,
    output logic      [1:0]    s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // Character stream from the line or the host
    input  wire logic          char_valid,
    input  wire cip_char_s     char_in,
    // Results
    output logic               pass_valid,
    output logic      [7:0]    pass_char,
    output logic               bcc_valid,
    output logic      [7:0]    bcc_value,
    output logic               transparent,
    output logic               flow_halt,
    output logic               irq
);
    typedef struct packed {
        cip_flow_e        flow;
        logic             lrc, transp, started, acc_on;
        logic             prev_dle, pend_dle, chk;
        logic [7:0]       dle;
        logic [NEV-1:0]   stat, mask;
        logic             irq;
        logic             pass_v;
        logic [7:0]       pass_c;
        logic             bcc_v;
        logic [7:0]       bcc_c;
        logic             aw_ok, w_ok;
        logic [AW-1:0]    awa;
        logic [31:0]      wd;
        logic [3:0]       ws;
        logic             awready, wready, bvalid;
        logic [1:0]       bresp;
        logic             arready, rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
        logic             tbl_we;
        logic [3:0]       tbl_wa;
        logic [15:0]      tbl_wd;
    } cip_main_s;

    cip_main_s   q, d;
    cip_char_s   c;
    cip_fn_s     fn;
    logic [15:0] word_a, word_b;
    logic [7:0]  acc, acc_nx;
    logic        acc_clr, add_a, add_b, is_dle, drop, skip, on;
    logic [NEV-1:0] ev;
    logic [31:0] wm;
    logic        wr_go;

    function automatic logic is_tbl(input logic [AW-1:0] a);
        return a[AW-1:6] == REG_TBL[AW-1:6];
    endfunction : is_tbl

    function automatic logic [31:0] wmerge(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[8*i +: 8] = n[8*i +: 8];
        return r;
    endfunction : wmerge

    ////////////////////////////////////////////////////////////////////
    cip_interp_table #(
        .DEPTH (16)
    ) u_table (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (q.tbl_we),
        .waddr   (q.tbl_wa),
        .wdata   (q.tbl_wd),
        .raddr_a (char_in.word),
        .rdata_a (word_a),
        .raddr_b (wr_go ? q.awa[5:2] : s_axi_araddr[5:2]),
        .rdata_b (word_b)
    );

    cip_block_check u_bcc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (acc_clr),
        .a_en    (add_a),
        .a       (char_in.data),
        .b_en    (add_b),
        .b       (q.dle),
        .acc     (acc)
    );

    assign c  = char_in;
    assign fn = c.ctrl ? cip_decode(word_a) : '0;
    assign wr_go = q.aw_ok && q.w_ok && !q.bvalid;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d         = q;
        d.pass_v  = 1'b0;
        d.bcc_v   = 1'b0;
        d.tbl_we  = 1'b0;
        ev        = '0;
        acc_clr   = 1'b0;
        add_a     = 1'b0;
        add_b     = 1'b0;
        is_dle    = c.data == q.dle;
        drop      = fn.excl & q.prev_dle & q.started & q.lrc;
        skip      = fn.skip & ~q.transp;
        on        = q.acc_on | fn.stbcc;
        wm        = 32'h0;
        acc_nx    = acc;
        if (char_valid && q.flow != FLOW_HALT)
        begin
            d.prev_dle = is_dle;
            if (q.chk)
            begin
                // The character after end or ITB is the check byte
                d.chk      = 1'b0;
                d.pend_dle = 1'b0;
                acc_clr    = 1'b1;
                ev[EV_BCCERR] = c.data != acc;
                if (q.flow == FLOW_CHECK)
                    d.flow = FLOW_HALT;
            end
            else
            begin
                d.acc_on   = on;
                d.started  = q.started | fn.stch;
                // DLE is held back until we know if the pair is dropped
                d.pend_dle = is_dle & on;
                add_b      = q.pend_dle & ~drop;
                add_a      = on & ~skip & ~drop & ~is_dle;
                acc_nx     = acc ^ (add_a ? c.data : 8'h00)
                                 ^ (add_b ? q.dle : 8'h00);
                d.pass_v   = ~(fn.supch & ~c.dir_out);
                d.pass_c   = c.data;
                if (fn.settr && q.prev_dle)
                    d.transp = 1'b1;
                else if (fn.rsttr && !c.dir_out && q.prev_dle
                         && (fn.fin || fn.itb))
                    d.transp = 1'b0;
                if (fn.itb)
                begin
                    ev[EV_ITB] = 1'b1;
                    if (c.dir_out)
                    begin
                        d.bcc_v = 1'b1;
                        d.bcc_c = acc_nx;
                        acc_clr = 1'b1;
                    end
                    else
                        d.chk = 1'b1;
                end
                if (fn.fin)
                begin
                    ev[EV_END] = 1'b1;
                    if (c.dir_out)
                    begin
                        d.bcc_v = 1'b1;
                        d.bcc_c = acc_nx;
                        d.flow  = FLOW_HALT;
                    end
                    else
                    begin
                        d.chk  = 1'b1;
                        d.flow = FLOW_CHECK;
                    end
                end
                if (fn.abort && !c.dir_out && q.started)
                begin
                    ev[EV_ABORT] = 1'b1;
                    d.flow       = FLOW_HALT;
                end
                ev[EV_MON] = fn.mon & c.dir_out;
            end
        end
        ev[EV_TRANS] = d.transp != q.transp;

        ////////////////////////////////////////////////////////////////
        // Write channel: address and data taken in either order
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_ok = 1'b1;
            d.awa   = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_ok = 1'b1;
            d.wd   = s_axi_wdata;
            d.ws   = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
            d.bvalid = 1'b0;
        if (wr_go)
        begin
            d.aw_ok  = 1'b0;
            d.w_ok   = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = RESP_OK;
            if (is_tbl(q.awa))
            begin
                wm       = wmerge({16'h0, word_b}, q.wd, q.ws);
                d.tbl_we = 1'b1;
                d.tbl_wa = q.awa[5:2];
                d.tbl_wd = wm[15:0];
            end
            else
            begin
                case (q.awa)
                    REG_CTRL:
                    begin
                        wm    = wmerge({30'h0, 1'b0, q.lrc}, q.wd, q.ws);
                        d.lrc = wm[CTRL_LRC];
                        if (wm[CTRL_CMD])
                        begin
                            // New command restarts the data flow
                            d.flow     = FLOW_RUN;
                            d.chk      = 1'b0;
                            d.started  = 1'b0;
                            d.acc_on   = 1'b0;
                            d.pend_dle = 1'b0;
                            acc_clr    = 1'b1;
                        end
                    end
                    REG_MASK:
                    begin
                        wm     = wmerge({26'h0, q.mask}, q.wd, q.ws);
                        d.mask = wm[NEV-1:0];
                    end
                    REG_DLE:
                    begin
                        wm    = wmerge({24'h0, q.dle}, q.wd, q.ws);
                        d.dle = wm[7:0];
                    end
                    REG_STAT, REG_STATE: ;
                    default: d.bresp = RESP_ERR;
                endcase
            end
        end
        d.awready = ~d.aw_ok & ~d.bvalid;
        d.wready  = ~d.w_ok & ~d.bvalid;

        ////////////////////////////////////////////////////////////////
        // Read channel; a status read clears it, a new event wins
        d.stat = q.stat;
        if (q.rvalid && s_axi_rready)
            d.rvalid = 1'b0;
        if (s_axi_arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OK;
            d.rdata  = 32'h0;
            if (is_tbl(s_axi_araddr))
                d.rdata = {16'h0, word_b};
            else
            begin
                case (s_axi_araddr)
                    REG_CTRL:  d.rdata = {31'h0, q.lrc};
                    REG_STAT:
                    begin
                        d.rdata = {26'h0, q.stat};
                        d.stat  = '0;
                    end
                    REG_MASK:  d.rdata = {26'h0, q.mask};
                    REG_STATE: d.rdata = {16'h0, acc, q.flow, q.chk,
                                          q.started, q.acc_on, q.transp,
                                          q.pend_dle};
                    REG_DLE:   d.rdata = {24'h0, q.dle};
                    default:   d.rresp = RESP_ERR;
                endcase
            end
        end
        // Table read port is lent to the write merge for one cycle
        d.arready = ~d.rvalid & ~(d.aw_ok & d.w_ok & ~d.bvalid);
        d.stat    = d.stat | ev;
        d.irq     = |(d.stat & d.mask);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q      <= '0;
            q.flow <= FLOW_RUN;
            q.dle  <= DLE_RESET;
        end
        else
            q <= d;
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rdata   = q.rdata;
    assign pass_valid    = q.pass_v;
    assign pass_char     = q.pass_c;
    assign bcc_valid     = q.bcc_v;
    assign bcc_value     = q.bcc_c;
    assign transparent   = q.transp;
    assign flow_halt     = q.flow[2];
    assign irq           = q.irq;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic run;
    assign run = char_valid && q.flow == FLOW_RUN && !q.chk && c.ctrl;

    a_supp_input: assert property (
        run && fn.supch && !c.dir_out |=> !pass_valid)
        else $error("suppressed input char reached host");
    a_skip_pass: assert property (
        run && fn.skip && !fn.supch
            |=> pass_valid && pass_char == $past(c.data)
            ##1 (!pass_valid || $past(char_valid)))
        else $error("check-skipped char not passed once");
    a_enter_transp: assert property (
        run && fn.settr && q.prev_dle |=> transparent)
        else $error("transparent mode not entered");
    a_transp_dle: assert property (
        !q.prev_dle && !transparent |=> !transparent)
        else $error("transparent entered without DLE");
    a_exit_gate: assert property (
        run && transparent && !fn.fin && !fn.itb |=> transparent)
        else $error("left transparent without end or ITB");
    a_exit_input: assert property (
        run && transparent && c.dir_out && !fn.settr |=> transparent)
        else $error("left transparent on output");
    a_end_stops: assert property (
        run && fn.fin && c.dir_out |=> flow_halt && bcc_valid)
        else $error("output end did not halt");
    a_itb_sends: assert property (
        run && fn.itb && c.dir_out |=> bcc_valid && !flow_halt
            && $past(acc_nx) == bcc_value ##0 acc == 8'h00)
        else $error("ITB did not send and restart check");
    a_combo_itb: assert property (
        run && word_a[B0_END] && word_a[B0_MON] && !fn.abort
            |=> !flow_halt && q.flow == FLOW_RUN)
        else $error("end plus monitor stopped the flow");
    a_skip_acc: assert property (
        run && fn.skip && !q.transp && !q.pend_dle && !fn.itb
            |=> acc == $past(acc))
        else $error("skipped char entered the check");
    a_dle_drop: assert property (
        run && fn.excl && q.prev_dle && q.pend_dle && q.started
            && q.lrc && !fn.itb && !is_dle |=> acc == $past(acc))
        else $error("DLE pair entered the check");
    a_lrc_only: assert property (
        run && fn.excl && q.pend_dle && !q.lrc && q.acc_on && !skip
            && !fn.itb && !is_dle
            |=> acc == ($past(acc) ^ $past(c.data) ^ q.dle))
        else $error("DLE exclusion active without LRC");
endmodule : cip_char_interp
`default_nettype wire

/* File: cip_term_model.sv */
// Remote terminal model: puts characters onto the interpreter's stream.
// Assumes: a caller invokes send, one character at a time.
`timescale 1ns/10ps
`default_nettype none
module cip_term_model
    import cip_pkg::*;
(
    // Clock
    input  wire logic       aclk,
    // Character stream
    output var  logic       char_valid,
    output var  cip_char_s  char_in
);
    initial
    begin
        char_valid = 1'b0;
        char_in    = '0;
    end

    // Held from one edge to the taking edge, then released
    task automatic send(input logic [7:0] d, input logic c,
                        input logic [3:0] w, input logic o);
        @(posedge aclk);
        char_valid <= 1'b1;
        char_in    <= '{data: d, ctrl: c, word: w, dir_out: o};
        @(posedge aclk);
        char_valid <= 1'b0;
        // Idle line must not show a stale character
        char_in    <= ~char_in;
    endtask : send
endmodule : cip_term_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench of the control character interpreter.
// Assumes: package, design and terminal model compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import cip_pkg::*;
;
    logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]   s_axi_wdata, s_axi_rdata;
    logic [3:0]    s_axi_wstrb;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    logic          aclk, aresetn, s_axi_awvalid, s_axi_awready;
    logic          s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic          s_axi_rready, char_valid, pass_valid, bcc_valid;
    logic          transparent, flow_halt, irq;
    logic [7:0]    pass_char, bcc_value;
    cip_char_s     char_in;
    int            err_total = 0, num_checks = 0, cyc = 0;
    localparam logic [15:0] TBL [16] = '{16'h0801, 16'h0000, 16'h1101,
        16'h4800, 16'h0000, 16'h0008, 16'h0001, 16'h0000, 16'h4200,
        16'h0002, 16'h0004, 16'h8004, 16'h0000, 16'h0000, 16'h0000,
        16'hffff};

    cip_char_interp cip_char_interp_inst
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .char_valid, .char_in, .pass_valid,
        .pass_char, .bcc_valid, .bcc_value, .transparent, .flow_halt, .irq
    );
    cip_term_model cip_term_model_inst
    (
        .aclk, .char_valid, .char_in
    );

    always #5 aclk = ~aclk;

    // Hang guard, far above the length of the sequence
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic results();
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & m, e);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rd

    // Outputs are looked at once the taking edge has landed
    task automatic snd(input logic [7:0] d, input logic c,
                       input logic [3:0] w, input logic o);
        cip_term_model_inst.send(d, c, w, o);
        #1;
    endtask : snd

    task automatic dle(input logic [3:0] w, input logic [7:0] d,
                       input logic o);
        snd(DLE_RESET, 1'b0, 4'h0, o);
        snd(d, 1'b1, w, o);
    endtask : dle

    // Start, data, sync filler, then a DLE pair; accumulator read back
    task automatic frame(input logic lrc, input logic [3:0] w,
                         input logic [7:0] acc);
        wr(REG_CTRL, {30'h0, 1'b1, lrc}, RESP_OK);
        snd(8'h01, 1'b1, 4'h2, 1'b0);
        chk(32'({pass_valid, pass_char}), 32'h101);
        snd(8'h41, 1'b0, 4'h0, 1'b0);
        snd(8'h16, 1'b1, 4'h0, 1'b0);
        chk(32'(pass_valid), 32'h0);
        dle(w, 8'h5a, 1'b0);
        rd(REG_STATE, {16'h0, acc, 8'h0}, 32'hff00, RESP_OK);
    endtask : frame
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(REG_DLE, 32'h10, 32'hff, RESP_OK);
        rd(REG_MASK, 32'h0, 32'h3f, RESP_OK);
        wr(8'h30, 32'h1, RESP_ERR);
        rd(8'h30, 32'h0, 32'h0, RESP_ERR);
        for (int i = 0; i < 16; i++)
            wr(REG_TBL + 8'(4 * i), {16'h0, TBL[i]}, RESP_OK);
        rd(REG_TBL + 8'h3c, 32'hff0f, 32'hffff, RESP_OK);
        s_axi_wstrb <= 4'h1;
        wr(REG_TBL + 8'h30, 32'hffff, RESP_OK);
        s_axi_wstrb <= 4'hf;
        rd(REG_TBL + 8'h30, 32'h000f, 32'hffff, RESP_OK);
        frame(1'b1, 4'h5, 8'h41);
        frame(1'b0, 4'h5, 8'h0b);
        frame(1'b1, 4'h6, 8'h51);
        snd(8'h03, 1'b1, 4'h3, 1'b0);
        chk(32'(pass_valid), 32'h0);
        snd(8'h52, 1'b0, 4'h0, 1'b0);
        chk(32'({flow_halt, irq}), 32'h2);
        snd(8'h41, 1'b0, 4'h0, 1'b0);
        chk(32'(pass_valid), 32'h0);
        wr(REG_MASK, 32'h1, RESP_OK);
        repeat (2) @(posedge aclk);
        #1;
        chk(32'(irq), 32'h1);
        rd(REG_STAT, 32'h1, 32'h1, RESP_OK);
        repeat (2) @(posedge aclk);
        #1;
        chk(32'(irq), 32'h0);
        wr(REG_CTRL, 32'h3, RESP_OK);
        snd(8'h01, 1'b1, 4'h2, 1'b1);
        snd(8'h41, 1'b0, 4'h0, 1'b1);
        snd(8'h17, 1'b1, 4'h8, 1'b1);
        chk(32'({bcc_valid, flow_halt}), 32'h2);
        chk(32'(bcc_value), 32'h56);
        wr(REG_CTRL, 32'h2, RESP_OK);
        dle(4'h9, 8'h02, 1'b1);
        chk(32'(transparent), 32'h1);
        dle(4'ha, 8'h03, 1'b0);
        chk(32'(transparent), 32'h1);
        dle(4'hb, 8'h17, 1'b1);
        chk(32'(transparent), 32'h1);
        dle(4'hb, 8'h17, 1'b0);
        chk(32'(transparent), 32'h0);
        snd(8'h01, 1'b0, 4'h0, 1'b0);
        rd(REG_STAT, 32'h10, 32'h10, RESP_OK);
        wr(REG_CTRL, 32'h2, RESP_OK);
        snd(8'h03, 1'b1, 4'h3, 1'b1);
        chk(32'({bcc_valid, flow_halt, bcc_value}), 32'h300);
        results();
    end
endmodule : tb_top
`default_nettype wire
